/* rtl/t1rx_front_end.sv */
`timescale 1ns/1ns
module t1rx_front_end (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire t1rx_pkg::t1rx_avm_req_type avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic analog_line_in_a_i,
  input wire logic analog_line_in_b_i,
  input wire logic [2:0] analog_pulse_level_i,
  input wire logic rail_in_positive_i,
  input wire logic rail_in_negative_i,
  input wire logic line_bit_strobe_i,
  input wire logic optical_data_in_i,
  input wire logic optical_receive_clock_in_i,
  input wire logic sync_in_i,
  input wire logic tx_data_i,
  input wire logic tx_bit_strobe_i,
  output logic rx_data_o,
  output logic rx_data_valid_o,
  output logic route_clock_o,
  output logic los_o,
  output logic ais_o,
  output logic los_irq_o,
  output logic equalizer_enable_o,
  output logic clk16_en_o,
  output logic clk8_en_o,
  output logic clk4_en_o,
  output logic clk2_en_o,
  output logic frame_8k_o,
  output logic tx_line_data_o
);
  import t1rx_pkg::*;

  typedef struct packed {
    t1rx_ctrl_type ctrl;
    logic [2:0] level;
    logic [7:0] detect;
    logic [7:0] recover;
    logic [7:0] limit2;
    logic waitreq;
    logic [31:0] rdata;
    logic opt_clk_q;
    logic sym_en;
    logic sym_pos;
    logic sym_neg;
    logic sym_opt;
    logic rx_data;
    logic rx_valid;
    logic [2:0] route_div;
    logic route_clk;
    logic [15:0] cvc;
    logic [1:0] events;
    logic los_q;
    logic irq;
    logic [11:0] ais_win;
    logic [7:0] ais_zeros;
    logic ais;
    t1rx_clk_src_type src;
    logic sync_q;
    logic [7:0] sync_idle;
    logic [8:0] ref_cnt;
    logic ref_tick;
    logic [31:0] dco_acc;
    logic [31:0] dco_inc;
    logic [2:0] div;
    logic [7:0] ph;
    logic clk16;
    logic clk8;
    logic clk4;
    logic clk2;
    logic fr8k;
    logic [JA_DEPTH-1:0] ja_mem;
    logic [8:0] wp;
    logic [8:0] rp;
    logic [8:0] fill;
    logic tx_data;
  } t1rx_st_type;

  t1rx_st_type s, n;
  logic dec_valid, dec_data, dec_cv, los;
  logic req, taken, opt_mode, above, sync_rise, ja_active, ja_wr, ja_rd;
  logic [32:0] dco_sum;
  logic [8:0] ref_last;

  // bipolar stream only reaches the decoder outside optical mode
  t1rx_decoder u_decoder (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .sym_en_i(s.sym_en & ~s.sym_opt),
    .sym_pos_i(s.sym_pos),
    .sym_neg_i(s.sym_neg),
    .b8zs_select_i(s.ctrl.b8zs_select),
    .data_valid_o(dec_valid),
    .data_o(dec_data),
    .code_violation_o(dec_cv)
  );

  t1rx_los u_los (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .sym_en_i(s.sym_en),
    .pulse_i(s.sym_pos | s.sym_neg),
    .detect_count_i(s.detect),
    .recover_count_i(s.recover),
    .limit2_i(s.limit2),
    .los_o(los)
  );

  // wrap-around increment for the jitter buffer pointers
  function automatic logic [8:0] ja_next(input logic [8:0] p);
    ja_next = (p == JA_LAST) ? 9'h000 : p + 9'h001;
  endfunction

  always_comb begin
    n = s;
    // register bus: first cycle latches read data, second cycle commits
    req = avs_req_i.read | avs_req_i.write;
    taken = req & ~s.waitreq;
    n.waitreq = ~(req & s.waitreq);
    if (req && s.waitreq) begin
      n.rdata = 32'h0000_0000;
      if (avs_req_i.address == REG_CTRL) begin
        n.rdata[9:0] = s.ctrl;
      end else if (avs_req_i.address == REG_LEVEL) begin
        n.rdata[2:0] = s.level;
      end else if (avs_req_i.address == REG_DETECT) begin
        n.rdata[7:0] = s.detect;
      end else if (avs_req_i.address == REG_RECOVER) begin
        n.rdata[7:0] = s.recover;
      end else if (avs_req_i.address == REG_LIMIT2) begin
        n.rdata[7:0] = s.limit2;
      end else if (avs_req_i.address == REG_STATUS) begin
        n.rdata[5:0] = {s.src, ja_active, s.ais, s.los_q};
      end else if (avs_req_i.address == REG_EVENTS) begin
        n.rdata[1:0] = s.events;
      end else if (avs_req_i.address == REG_CVC) begin
        n.rdata[15:0] = s.cvc;
      end
    end
    if (taken && avs_req_i.write) begin
      if (avs_req_i.address == REG_CTRL) begin
        n.ctrl = t1rx_ctrl_type'(avs_req_i.writedata[9:0]);
      end else if (avs_req_i.address == REG_LEVEL) begin
        n.level = avs_req_i.writedata[2:0];
      end else if (avs_req_i.address == REG_DETECT) begin
        n.detect = avs_req_i.writedata[7:0];
      end else if (avs_req_i.address == REG_RECOVER) begin
        n.recover = avs_req_i.writedata[7:0];
      end else if (avs_req_i.address == REG_LIMIT2) begin
        n.limit2 = avs_req_i.writedata[7:0];
      end
    end

    // input selection and bit strobe
    opt_mode = s.ctrl.digital_receive_select & ~s.ctrl.receive_code_select;
    above = analog_pulse_level_i >= s.level;
    n.opt_clk_q = optical_receive_clock_in_i;
    n.sym_opt = opt_mode;
    if (opt_mode) begin
      n.sym_en = s.opt_clk_q & ~optical_receive_clock_in_i;
      n.sym_pos = optical_data_in_i;
      n.sym_neg = 1'b0;
    end else if (s.ctrl.digital_receive_select) begin
      n.sym_en = line_bit_strobe_i;
      n.sym_pos = rail_in_positive_i;
      n.sym_neg = rail_in_negative_i;
    end else begin
      n.sym_en = line_bit_strobe_i;
      n.sym_pos = analog_line_in_a_i & above;
      n.sym_neg = analog_line_in_b_i & above;
    end

    // received data: optical is plain NRZ, the rest comes decoded
    if (s.sym_opt) begin
      n.rx_valid = s.sym_en;
      n.rx_data = s.sym_pos;
    end else begin
      n.rx_valid = dec_valid;
      n.rx_data = dec_data;
    end

    // read takes off what it returned, so a count after the latch survives
    if (taken && avs_req_i.read && avs_req_i.address == REG_CVC) begin
      n.cvc = s.cvc - s.rdata[15:0];
    end
    if (dec_cv && n.cvc != 16'hFFFF) begin
      n.cvc = n.cvc + 16'h0001;
    end

    // loss events: sticky, cleared by read, set wins over clear
    n.los_q = los;
    if (taken && avs_req_i.read && avs_req_i.address == REG_EVENTS) begin
      n.events = s.events & ~s.rdata[1:0];
    end
    if (los && !s.los_q) begin
      n.events[EV_LOS_BIT] = 1'b1;
    end
    if (los != s.los_q) begin
      n.events[EV_CHG_BIT] = 1'b1;
    end
    n.irq = (n.events[EV_LOS_BIT] & ~s.ctrl.los_irq_mask) |
      (n.events[EV_CHG_BIT] & s.ctrl.status_change_irq_enable);

    // blue alarm: too few zeros in a window of received bits
    if (s.rx_valid) begin
      n.ais_win = s.ais_win + 12'h001;
      if (!s.rx_data && s.ais_zeros != 8'hFF) begin
        n.ais_zeros = s.ais_zeros + 8'h01;
      end
      if (s.ais_win == AIS_WINDOW_LAST) begin
        n.ais = n.ais_zeros < AIS_ZERO_LIMIT;
        n.ais_win = 12'h000;
        n.ais_zeros = 8'h00;
      end
    end

    // route clock follows the line, divides the system clock by 8 when lost
    n.route_div = s.route_div + 3'h1;
    if (los) begin
      n.route_clk = n.route_div[2];
    end else if (s.sym_en) begin
      n.route_clk = 1'b1;
      n.route_div = 3'h0;
    end else if (s.route_div == 3'h3) begin
      n.route_clk = 1'b0;
    end

    // sync input counts as grounded after a quiet spell
    sync_rise = sync_in_i & ~s.sync_q;
    n.sync_q = sync_in_i;
    if (sync_rise) begin
      n.sync_idle = 8'h00;
    end else if (s.sync_idle != SYNC_IDLE_CYCLES) begin
      n.sync_idle = s.sync_idle + 8'h01;
    end

    // clock source: line in slave mode, but loss falls back to master
    if (!s.ctrl.master_select && !los) begin
      n.src = SRC_LINE;
    end else if (s.sync_idle != SYNC_IDLE_CYCLES) begin
      n.src = SRC_SYNC;
    end else begin
      n.src = SRC_FREE;
    end

    // 8 kHz reference: 193 line bits, or sync divided per its rate
    if (s.src == SRC_LINE) begin
      ref_last = LINE_FRAME_LAST;
    end else if (s.ctrl.oscillator_clock_select) begin
      ref_last = SYNC2048_LAST;
    end else begin
      ref_last = SYNC1544_LAST;
    end
    n.ref_tick = 1'b0;
    if ((s.src == SRC_LINE && s.sym_en) || (s.src == SRC_SYNC && sync_rise)) begin
      if (s.ref_cnt >= ref_last) begin
        n.ref_cnt = 9'h000;
        n.ref_tick = 1'b1;
      end else begin
        n.ref_cnt = s.ref_cnt + 9'h001;
      end
    end

    // phase accumulator at 16.384 MHz, divided to the lower clocks
    dco_sum = {1'b0, s.dco_acc} + {1'b0, s.dco_inc};
    n.dco_acc = dco_sum[31:0];
    n.clk16 = dco_sum[32];
    n.clk8 = dco_sum[32] & s.div[0];
    n.clk4 = dco_sum[32] & (&s.div[1:0]);
    n.clk2 = dco_sum[32] & (&s.div);
    n.fr8k = n.clk2 & (&s.ph);
    if (dco_sum[32]) begin
      n.div = s.div + 3'h1;
    end
    if (n.clk2) begin
      n.ph = s.ph + 8'h01;
    end
    // bang-bang lock; the pull limit keeps a bad reference from running away
    if (s.src == SRC_FREE) begin
      n.dco_inc = DCO_NOM_INC;
    end else if (s.ref_tick) begin
      if (s.ph[7] && s.dco_inc < DCO_NOM_INC + DCO_PULL) begin
        n.dco_inc = s.dco_inc + DCO_STEP;
      end else if (!s.ph[7] && s.dco_inc > DCO_NOM_INC - DCO_PULL) begin
        n.dco_inc = s.dco_inc - DCO_STEP;
      end
    end

    // jitter buffer: received bits in, transmit strobe out, kept half full
    ja_active = s.ctrl.jitter_attenuator_enable & s.ctrl.remote_loop;
    ja_wr = ja_active & s.rx_valid;
    ja_rd = ja_active & tx_bit_strobe_i;
    if (!ja_active) begin
      n.wp = JA_HALF;
      n.rp = 9'h000;
      n.fill = JA_HALF;
      if (tx_bit_strobe_i) begin
        n.tx_data = tx_data_i;
      end
    end else begin
      if (ja_wr) begin
        n.ja_mem[s.wp] = s.rx_data;
        n.wp = ja_next(s.wp);
      end
      if (ja_rd) begin
        n.tx_data = s.ja_mem[s.rp];
        n.rp = ja_next(s.rp);
      end
      if (ja_wr && !ja_rd) begin
        n.fill = s.fill + 9'h001;
      end else if (ja_rd && !ja_wr) begin
        n.fill = s.fill - 9'h001;
      end
      // slip by recentring rather than losing pointer order
      if ((ja_wr && !ja_rd && s.fill == JA_LAST) || (ja_rd && !ja_wr && s.fill == 9'h001)) begin
        n.rp = (n.wp >= JA_HALF) ? n.wp - JA_HALF : n.wp + JA_HALF;
        n.fill = JA_HALF;
      end
    end
  end

  // single state register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.ctrl <= t1rx_ctrl_type'(CTRL_RST);
      s.level <= LEVEL_RST;
      s.detect <= DETECT_RST;
      s.recover <= RECOVER_RST;
      s.limit2 <= LIMIT2_RST;
      s.waitreq <= 1'b1;
      s.src <= SRC_FREE;
      s.dco_inc <= DCO_NOM_INC;
      s.wp <= JA_HALF;
      s.fill <= JA_HALF;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign avs_readdata_o = s.rdata;
  assign avs_waitrequest_o = s.waitreq;
  assign rx_data_o = s.rx_data;
  assign rx_data_valid_o = s.rx_valid;
  assign route_clock_o = s.route_clk;
  assign los_o = s.los_q;
  assign ais_o = s.ais;
  assign los_irq_o = s.irq;
  assign equalizer_enable_o = s.ctrl.equalizer_enable;
  assign clk16_en_o = s.clk16;
  assign clk8_en_o = s.clk8;
  assign clk4_en_o = s.clk4;
  assign clk2_en_o = s.clk2;
  assign frame_8k_o = s.fr8k;
  assign tx_line_data_o = s.tx_data;
endmodule

/* rtl/t1rx_pkg.sv */
package t1rx_pkg;
  // bus map, byte addresses
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_LEVEL = 5'h04;
  localparam logic [4:0] REG_DETECT = 5'h08;
  localparam logic [4:0] REG_RECOVER = 5'h0C;
  localparam logic [4:0] REG_LIMIT2 = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_EVENTS = 5'h18;
  localparam logic [4:0] REG_CVC = 5'h1C;
  // reset values
  localparam logic [9:0] CTRL_RST = 10'h100;
  localparam logic [2:0] LEVEL_RST = 3'h0;
  localparam logic [7:0] DETECT_RST = 8'h0F;
  localparam logic [7:0] RECOVER_RST = 8'h0F;
  localparam logic [7:0] LIMIT2_RST = 8'h00;
  // field positions
  localparam int SECOND_LIMIT_REGISTER_CONSEC_BIT = 0;
  localparam int EV_LOS_BIT = 0;
  localparam int EV_CHG_BIT = 1;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam longint CLK_HZ = 50000000;
  localparam longint DCO_OUT_HZ = 16384000;
  localparam int SYNC_IDLE_NS = 4000;
  localparam logic [7:0] SYNC_IDLE_CYCLES =
    8'((SYNC_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] DCO_NOM_INC = 32'((64'(DCO_OUT_HZ) << 32) / 64'(CLK_HZ));
  localparam logic [31:0] DCO_STEP = 32'h0000_2000;
  localparam logic [31:0] DCO_PULL = 32'h0040_0000;
  localparam logic [8:0] LINE_FRAME_LAST = 9'h0C0;
  localparam logic [8:0] SYNC1544_LAST = 9'h0C0;
  localparam logic [8:0] SYNC2048_LAST = 9'h0FF;
  localparam logic [12:0] LOS_DETECT_MAX = 13'h1000;
  localparam logic [11:0] AIS_WINDOW_LAST = 12'h7FF;
  localparam logic [7:0] AIS_ZERO_LIMIT = 8'h03;
  localparam int JA_DEPTH = 288;
  localparam logic [8:0] JA_LAST = 9'h11F;
  localparam logic [8:0] JA_HALF = 9'h090;
  // line symbols
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_POS = 2'h1;
  localparam logic [1:0] SYM_NEG = 2'h2;

  typedef struct packed {
    logic los_irq_mask;
    logic equalizer_enable;
    logic remote_loop;
    logic jitter_attenuator_enable;
    logic status_change_irq_enable;
    logic oscillator_clock_select;
    logic master_select;
    logic b8zs_select;
    logic receive_code_select;
    logic digital_receive_select;
  } t1rx_ctrl_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } t1rx_avm_req_type;

  typedef enum logic [1:0] {LOS_CLEAR = 2'b01, LOS_ACTIVE = 2'b10} t1rx_los_state_type;
  typedef enum logic [2:0] {
    SRC_FREE = 3'b001, SRC_SYNC = 3'b010, SRC_LINE = 3'b100
  } t1rx_clk_src_type;
endpackage

/* rtl/t1rx_decoder.sv */
`timescale 1ns/1ns
module t1rx_decoder (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic sym_en_i,
  input wire logic sym_pos_i,
  input wire logic sym_neg_i,
  input wire logic b8zs_select_i,
  output logic data_valid_o,
  output logic data_o,
  output logic code_violation_o
);
  import t1rx_pkg::*;

  typedef struct packed {
    logic [7:0][1:0] win;
    logic [7:0] cvw;
    logic last_neg;
    logic out_neg;
    logic valid;
    logic data;
    logic cv;
  } t1rx_dec_st_type;

  t1rx_dec_st_type s, n;
  logic [1:0] sym;

  // substitution 000VB0VB relative to the pulse before the window
  function automatic logic b8zs_hit(input logic [7:0][1:0] w, input logic p_neg);
    logic [1:0] same;
    logic [1:0] opp;
    same = p_neg ? SYM_NEG : SYM_POS;
    opp = p_neg ? SYM_POS : SYM_NEG;
    b8zs_hit = (w[7] == SYM_ZERO) && (w[6] == SYM_ZERO) && (w[5] == SYM_ZERO) &&
      (w[4] == same) && (w[3] == opp) && (w[2] == SYM_ZERO) &&
      (w[1] == opp) && (w[0] == same);
  endfunction

  // eight-symbol delay lets a whole substitution be undone before output
  always_comb begin
    n = s;
    sym = SYM_ZERO;
    n.valid = 1'b0;
    n.cv = 1'b0;
    if (sym_en_i) begin
      if (sym_pos_i && !sym_neg_i) begin
        sym = SYM_POS;
      end else if (sym_neg_i && !sym_pos_i) begin
        sym = SYM_NEG;
      end
      n.valid = 1'b1;
      n.data = s.win[7] != SYM_ZERO;
      n.cv = s.cvw[7];
      if (s.win[7] != SYM_ZERO) begin
        n.out_neg = s.win[7] == SYM_NEG;
      end
      n.win = {s.win[6:0], sym};
      // same polarity twice, or both rails at once, is a bipolar violation
      n.cvw = {s.cvw[6:0], ((sym != SYM_ZERO) && ((sym == SYM_NEG) == s.last_neg)) ||
        (sym_pos_i && sym_neg_i)};
      if (sym != SYM_ZERO) begin
        n.last_neg = sym == SYM_NEG;
      end
      if (b8zs_select_i && b8zs_hit(n.win, n.out_neg)) begin
        n.win = '0;
        n.cvw = '0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign data_valid_o = s.valid;
  assign data_o = s.data;
  assign code_violation_o = s.cv;
endmodule

/* rtl/t1rx_los.sv */
`timescale 1ns/1ns
module t1rx_los (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic sym_en_i,
  input wire logic pulse_i,
  input wire logic [7:0] detect_count_i,
  input wire logic [7:0] recover_count_i,
  input wire logic [7:0] limit2_i,
  output logic los_o
);
  import t1rx_pkg::*;

  typedef struct packed {
    t1rx_los_state_type state;
    logic [12:0] cnt;
    logic [7:0] rec;
  } t1rx_los_st_type;

  t1rx_los_st_type s, n;
  logic [12:0] limit;
  logic [7:0] need;

  // zero detect count means the top of the range, zero recover count means one pulse
  always_comb begin
    n = s;
    limit = (detect_count_i == 8'h00) ? LOS_DETECT_MAX : {1'b0, detect_count_i, 4'h0};
    need = (recover_count_i == 8'h00) ? 8'h01 : recover_count_i;
    case (s.state)
      LOS_CLEAR: begin
        if (sym_en_i) begin
          if (pulse_i) begin
            n.cnt = '0;
          end else begin
            n.cnt = s.cnt + 13'h0001;
            if (n.cnt >= limit) begin
              n.state = LOS_ACTIVE;
              n.rec = '0;
            end
          end
        end
      end
      LOS_ACTIVE: begin
        if (sym_en_i) begin
          if (pulse_i) begin
            n.rec = s.rec + 8'h01;
            if (n.rec >= need) begin
              n.state = LOS_CLEAR;
              n.cnt = '0;
            end
          end else if (limit2_i[SECOND_LIMIT_REGISTER_CONSEC_BIT]) begin
            n.rec = '0;
          end
        end
      end
      default: begin
        n.state = LOS_CLEAR;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '{state: LOS_CLEAR, cnt: '0, rec: '0};
    end else begin
      s <= n;
    end
  end

  assign los_o = s.state == LOS_ACTIVE;
endmodule

/* verif/t1rx_checker.sv */
`timescale 1ns/1ns
// pin-level watch on the receive front end
module t1rx_checker (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire t1rx_pkg::t1rx_avm_req_type avs_req_i,
  input wire logic avs_waitrequest_o,
  input wire logic line_bit_strobe_i,
  input wire logic optical_receive_clock_in_i,
  input wire logic rx_data_valid_o,
  input wire logic tx_bit_strobe_i,
  input wire logic tx_line_data_o,
  input wire logic clk16_en_o,
  input wire logic frame_8k_o,
  input wire logic route_clock_o,
  input wire logic los_o,
  input wire logic equalizer_enable_o
);
  import t1rx_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // bus activity and a committed control write
  wire logic req_w = avs_req_i.read || avs_req_i.write;
  wire logic ctrl_wr_w = avs_req_i.write && !avs_waitrequest_o && avs_req_i.address == REG_CTRL;

  AST_ONE_WAIT: assert property (req_w && avs_waitrequest_o |=> !avs_waitrequest_o ##1
    avs_waitrequest_o) else $error("bus answer not after exactly one wait cycle");
  AST_NO_SPURIOUS: assert property (!avs_waitrequest_o |-> $past(req_w))
    else $error("bus answered without a request");
  AST_VALID_CAUSE: assert property (rx_data_valid_o |-> $past(line_bit_strobe_i, 3) ||
    $past(optical_receive_clock_in_i, 2) || $past(optical_receive_clock_in_i, 3) ||
    $past(optical_receive_clock_in_i, 4)) else $error("received bit without a line symbol");
  AST_TX_TIMING: assert property ($changed(tx_line_data_o) |-> $past(tx_bit_strobe_i))
    else $error("transmit bit moved without a strobe");
  AST_CLK16_GAP: assert property (clk16_en_o |=> !clk16_en_o [*2])
    else $error("16 MHz enable too dense");
  AST_FRAME_GAP: assert property (frame_8k_o |=> !frame_8k_o [*8])
    else $error("frame pulse too dense");
  // without signal the route clock flips every fourth cycle
  AST_ROUTE_FREE: assert property ($changed(route_clock_o) && los_o && $past(los_o, 2) |=>
    (!$changed(route_clock_o) || !los_o) [*3] ##1 ($changed(route_clock_o) || !los_o))
    else $error("route clock not at one eighth while lost");
  AST_EQ_FOLLOW: assert property (ctrl_wr_w |-> ##2
    equalizer_enable_o == $past(avs_req_i.writedata[8], 2))
    else $error("equalizer enable does not follow control write");

  cover property ($rose(los_o));
  cover property (rx_data_valid_o);
  cover property (frame_8k_o);
endmodule

bind t1rx_front_end t1rx_checker t1rx_checker_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .avs_req_i(avs_req_i), .avs_waitrequest_o(avs_waitrequest_o),
  .line_bit_strobe_i(line_bit_strobe_i), .optical_receive_clock_in_i(optical_receive_clock_in_i),
  .rx_data_valid_o(rx_data_valid_o), .tx_bit_strobe_i(tx_bit_strobe_i),
  .tx_line_data_o(tx_line_data_o), .clk16_en_o(clk16_en_o), .frame_8k_o(frame_8k_o),
  .route_clock_o(route_clock_o), .los_o(los_o), .equalizer_enable_o(equalizer_enable_o));

/* verif/t1rx_line_model.sv */
`timescale 1ns/1ns
// line receiver stand-in: one symbol per send request
module t1rx_line_model (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [1:0] sym_i,
  input wire logic [2:0] lvl_i,
  output logic strobe_o,
  output logic pos_o,
  output logic neg_o,
  output logic [2:0] level_o,
  output logic opt_data_o,
  output logic opt_clk_o
);
  import t1rx_pkg::*;
  initial begin
    {strobe_o, pos_o, neg_o, level_o, opt_data_o, opt_clk_o} = '0;
  end
  // optical clock pulses high one cycle, falls mid-bit, then stands low
  always @(posedge clk_i) begin
    strobe_o <= send_i;
    opt_clk_o <= send_i;
    if (send_i) begin
      pos_o <= sym_i == SYM_POS;
      neg_o <= sym_i == SYM_NEG;
      level_o <= lvl_i;
      opt_data_o <= sym_i != SYM_ZERO;
    end else begin
      // rails only mean something at the strobe, so let them wander
      pos_o <= ~pos_o;
      neg_o <= ~neg_o;
    end
  end
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import t1rx_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  t1rx_avm_req_type req = '0;
  logic send = 1'b0;
  logic [1:0] sym = SYM_ZERO;
  logic [2:0] lvl = 3'h7;
  logic sync_on = 1'b0;
  logic sync = 1'b0;
  logic txs = 1'b0;
  logic txd = 1'b0;
  logic last = 1'b0;
  logic [4:0] sc = 5'h00;
  logic [31:0] lfsr = 32'h7DFC;
  logic [31:0] rd, rdata;
  logic [2:0] plvl;
  logic wt, strobe, pos, neg, odat, oclk, rxd, rxv, los, ais, irq, eq, txo;
  logic [31:0] q[$];
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;

  t1rx_front_end t1rx_front_end_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .avs_req_i(req), .avs_readdata_o(rd), .avs_waitrequest_o(wt),
    .analog_line_in_a_i(pos), .analog_line_in_b_i(neg), .analog_pulse_level_i(plvl),
    .rail_in_positive_i(pos), .rail_in_negative_i(neg), .line_bit_strobe_i(strobe),
    .optical_data_in_i(odat), .optical_receive_clock_in_i(oclk), .sync_in_i(sync),
    .tx_data_i(txd), .tx_bit_strobe_i(txs), .rx_data_o(rxd), .rx_data_valid_o(rxv),
    .route_clock_o(), .los_o(los), .ais_o(ais), .los_irq_o(irq), .equalizer_enable_o(eq),
    .clk16_en_o(), .clk8_en_o(), .clk4_en_o(), .clk2_en_o(), .frame_8k_o(),
    .tx_line_data_o(txo));
  t1rx_line_model t1rx_line_model_i (.clk_i(sys_clk_i), .send_i(send), .sym_i(sym),
    .lvl_i(lvl), .strobe_o(strobe), .pos_o(pos), .neg_o(neg), .level_o(plvl),
    .opt_data_o(odat), .opt_clk_o(oclk));

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // sync near 1.544 MHz, held low when grounded; run ceiling
  always @(posedge sys_clk_i) begin
    sc <= sc + 5'h01;
    sync <= sync_on & sc[4];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  // optical bits come back in order; other modes leave the queue empty
  always @(negedge sys_clk_i) begin
    if (rxv === 1'b1 && q.size() > 0) begin
      cmp("rx_data", q.pop_front(), 32'(rxd));
    end
  end

  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // request held until waitrequest is sampled low at a rising edge, released there
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    req <= '{read: !wr, write: wr, address: a, writedata: d};
    @(posedge sys_clk_i);
    while (wt !== 1'b0) begin
      @(posedge sys_clk_i);
    end
    rdata = rd;
    req <= '0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp("readdata", e, rdata & m);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // one line symbol with a random transmit bit riding along
  task automatic tx_sym(input logic [1:0] s, input logic [2:0] l);
    @(posedge sys_clk_i);
    send <= 1'b1;
    sym <= s;
    lvl <= l;
    txs <= 1'b1;
    txd <= lfsr[7];
    lfsr = nx(lfsr);
    @(posedge sys_clk_i);
    send <= 1'b0;
    txs <= 1'b0;
    @(negedge sys_clk_i);
    cmp("tx_line", 32'(txd), 32'(txo));
    @(posedge sys_clk_i);
  endtask
  // marks alternate polarity, zeros stay empty
  task automatic mark(input logic b);
    if (b) begin
      last = ~last;
    end
    tx_sym(!b ? SYM_ZERO : last ? SYM_NEG : SYM_POS, 3'h7);
  endtask
  // eight zeros as 000VB0VB, leaving the polarity where it was
  task automatic subst();
    logic [1:0] v;
    logic [1:0] o;
    v = last ? SYM_NEG : SYM_POS;
    o = last ? SYM_POS : SYM_NEG;
    repeat (3) tx_sym(SYM_ZERO, 3'h7);
    tx_sym(v, 3'h7);
    tx_sym(o, 3'h7);
    tx_sym(SYM_ZERO, 3'h7);
    tx_sym(o, 3'h7);
    tx_sym(v, 3'h7);
  endtask

  initial begin
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd_chk(REG_CTRL, 32'h3FF, 32'(CTRL_RST));
    rd_chk(REG_DETECT, 32'hFF, 32'(DETECT_RST));
    rd_chk(REG_RECOVER, 32'hFF, 32'(RECOVER_RST));
    rd_chk(5'h02, 32'hFFFFFFFF, 32'h0);
    // dual rail AMI, random marks, then one bipolar violation
    bus(1'b1, REG_CTRL, 32'h003);
    for (int i = 0; i < 40; i++) mark(lfsr[3]);
    cmp("equalizer", 32'h0, 32'(eq));
    rd_chk(REG_CVC, 32'hFFFF, 32'h0);
    tx_sym(last ? SYM_NEG : SYM_POS, 3'h7);
    repeat (9) mark(1'b1);
    rd_chk(REG_CVC, 32'hFFFF, 32'h1);
    rd_chk(REG_CVC, 32'hFFFF, 32'h0);
    // substitution is legal under B8ZS, two violations under AMI
    for (int b = 0; b < 2; b++) begin
      bus(1'b1, REG_CTRL, 32'(3 + 4 * b));
      subst();
      repeat (9) mark(1'b1);
      rd_chk(REG_CVC, 32'hFFFF, (b == 1) ? 32'h0 : 32'h2);
    end
    // optical: every bit returns, nothing counted
    bus(1'b1, REG_CTRL, 32'h001);
    for (int i = 0; i < 24; i++) begin
      q.push_back(32'(lfsr[5]));
      tx_sym(lfsr[5] ? SYM_POS : SYM_ZERO, 3'h7);
    end
    idle(4);
    cmp("rx_pending", 32'h0, 32'(q.size()));
    rd_chk(REG_CVC, 32'hFFFF, 32'h0);
    // ternary: weak pulses are silence, a pulse at threshold restarts the count
    bus(1'b1, REG_CTRL, 32'h020);
    bus(1'b1, REG_LEVEL, 32'h4);
    bus(1'b1, REG_DETECT, 32'h1);
    bus(1'b1, REG_RECOVER, 32'h2);
    tx_sym(SYM_POS, 3'h7);
    repeat (15) tx_sym(SYM_NEG, 3'h3);
    tx_sym(SYM_POS, 3'h4);
    repeat (15) tx_sym(SYM_NEG, 3'h3);
    idle(6);
    cmp("los", 32'h0, 32'(los));
    tx_sym(SYM_NEG, 3'h3);
    idle(6);
    cmp("los", 32'h1, 32'(los));
    cmp("irq", 32'h1, 32'(irq));
    rd_chk(REG_STATUS, 32'h39, 32'h09);
    rd_chk(REG_EVENTS, 32'h3, 32'h3);
    idle(3);
    cmp("irq", 32'h0, 32'(irq));
    // recovery needs two strong pulses, not back to back
    tx_sym(SYM_POS, 3'h7);
    tx_sym(SYM_NEG, 3'h1);
    idle(6);
    cmp("los", 32'h1, 32'(los));
    tx_sym(SYM_POS, 3'h7);
    idle(6);
    cmp("los", 32'h0, 32'(los));
    rd_chk(REG_EVENTS, 32'h3, 32'h2);
    rd_chk(REG_STATUS, 32'h38, 32'h20);
    // master: lock to a running sync, free-run once grounded
    bus(1'b1, REG_CTRL, 32'h008);
    sync_on <= 1'b1;
    idle(100);
    rd_chk(REG_STATUS, 32'h38, 32'h10);
    sync_on <= 1'b0;
    idle(260);
    rd_chk(REG_STATUS, 32'h38, 32'h08);
    // transmit buffer needs both enable and remote loop
    bus(1'b1, REG_CTRL, 32'h040);
    rd_chk(REG_STATUS, 32'h4, 32'h0);
    bus(1'b1, REG_CTRL, 32'h0C0);
    rd_chk(REG_STATUS, 32'h4, 32'h4);
    // all marks for two windows raise blue alarm
    bus(1'b1, REG_CTRL, 32'h020);
    repeat (4096) mark(1'b1);
    cmp("ais", 32'h1, 32'(ais));
    // consecutive recovery: a silent period restarts the pulse count
    bus(1'b1, REG_LIMIT2, 32'h1);
    repeat (16) tx_sym(SYM_ZERO, 3'h7);
    for (int i = 0; i < 4; i++) tx_sym(i[0] ? SYM_ZERO : SYM_POS, 3'h7);
    idle(6);
    cmp("los", 32'h1, 32'(los));
    conclude();
  end
endmodule
